// ===== usb_uart_serial_port_core.sv
// serial port side of a usb to serial bridge
`timescale 1ns/100ps
module usb_uart_serial_port_core
    import uart_core_pkg::*;
#(
    parameter int          MS_CYCLES   = uart_core_pkg::CYCLES_PER_MS,
    parameter int          WAKE_CYCLES = uart_core_pkg::RI_WAKE_CYCLES,
    parameter logic [63:0] CHIP_ID     = 64'h0123_4567_89ab_cdef // arbitrary value
)(
    // clock and reset
    input  wire logic                 clock_i,
    input  wire logic                 sys_rst_i,
    // configuration from host, status to host
    input  wire logic                 config_load_i,
    input  wire logic [DIV_INT_W-1:0] divisor_int_i,
    input  wire logic [2:0]           divisor_frac_i,
    input  wire logic [7:0]           timeout_ms_i,
    input  wire logic [7:0]           invert_i,
    input  wire logic                 bleed_enable_i,
    input  wire logic                 power_off_i,
    input  wire logic                 remote_wake_enable_i,
    input  wire logic                 suspended_i,
    output logic                      config_error_o,
    output logic [63:0]               chip_id_o,
    output logic                      resume_o,
    // data from and to host
    input  wire logic                 tx_valid_i,
    input  wire logic [7:0]           tx_data_i,
    output logic                      tx_ready_o,
    output logic                      rx_valid_o,
    output logic [7:0]                rx_data_o,
    output logic                      rx_frame_error_o,
    output logic                      rx_flush_o,
    input  wire logic                 rts_req_i,
    input  wire logic                 dtr_req_i,
    output logic                      cts_o,
    output logic                      dsr_o,
    output logic                      dcd_o,
    output logic                      ri_o,
    // serial pins
    output logic                      txd_o,
    input  wire logic                 rxd_i,
    output logic                      rts_n_o,
    output logic                      dtr_n_o,
    input  wire logic                 cts_n_i,
    input  wire logic                 dsr_n_i,
    input  wire logic                 carrier_detect_n_i,
    input  wire logic                 ring_indicate_n_i,
    output logic                      power_enable_n_o,
    output logic                      bleed_pulldown_o
);
    import uart_core_pkg::*;

    // ****************************************
    // configuration, applied between characters
    // ****************************************
    logic [DIV_INT_W-1:0] pend_int, act_int;
    logic [2:0]           pend_frac, act_frac;
    logic [7:0]           pend_timeout, act_timeout;
    logic                 pend_valid, ever_applied;
    tx_state_type         tx_state;
    rx_state_type         rx_state;
    logic                 accept, apply;

    assign accept = tx_valid_i && tx_ready_o;
    assign apply  = pend_valid && (tx_state == TX_IDLE) && (rx_state == RX_IDLE) && !accept;

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            pend_int       <= DIV_INT_RESET;
            pend_frac      <= DIV_FRAC_RESET;
            pend_timeout   <= TIMEOUT_RESET;
            pend_valid     <= 1'b0;
            config_error_o <= 1'b0;
        end
        else
        begin
            config_error_o <= 1'b0;
            if (config_load_i)
            begin
                // illegal divisors and a zero timeout are refused whole
                if (div_legal(divisor_int_i, divisor_frac_i) && (timeout_ms_i != 8'h00))
                begin
                    pend_int     <= divisor_int_i;
                    pend_frac    <= divisor_frac_i;
                    pend_timeout <= timeout_ms_i;
                    pend_valid   <= 1'b1;
                end
                else
                    config_error_o <= 1'b1;
            end
            else if (apply)
                pend_valid <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            act_int      <= DIV_INT_RESET;
            act_frac     <= DIV_FRAC_RESET;
            act_timeout  <= TIMEOUT_RESET;
            ever_applied <= 1'b0;
        end
        else if (apply)
        begin
            act_int      <= pend_int;
            act_frac     <= pend_frac;
            act_timeout  <= pend_timeout;
            ever_applied <= 1'b1;
        end
    end

    // ****************************************
    // 3 mhz base tick and bit timers
    // ****************************************
    logic [7:0] base_acc;
    logic       base_tick;
    logic       tx_mid, tx_end, rx_mid, rx_end;
    logic       rx_line;
    logic       tx_wait;

    // 250 is not a multiple of 3, so an accumulator keeps the average rate exact
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            base_acc  <= 8'h00;
            base_tick <= 1'b0;
        end
        else if (base_acc >= BASE_MOD - BASE_STEP)
        begin
            base_acc  <= base_acc + BASE_STEP - BASE_MOD;
            base_tick <= 1'b1;
        end
        else
        begin
            base_acc  <= base_acc + BASE_STEP;
            base_tick <= 1'b0;
        end
    end

    frac_baud_gen tx_timer (
        .clock_i     (clock_i),
        .sys_rst_i   (sys_rst_i),
        .base_tick_i (base_tick),
        .divisor8_i  (div_eighths(act_int, act_frac)),
        .restart_i   (accept || tx_wait),
        .mid_o       (tx_mid),
        .end_o       (tx_end)
    );

    frac_baud_gen rx_timer (
        .clock_i     (clock_i),
        .sys_rst_i   (sys_rst_i),
        .base_tick_i (base_tick),
        .divisor8_i  (div_eighths(act_int, act_frac)),
        .restart_i   ((rx_state == RX_IDLE) && !rx_line),
        .mid_o       (rx_mid),
        .end_o       (rx_end)
    );

    // ****************************************
    // transmitter
    // ****************************************
    logic [7:0] tx_shift;
    logic [2:0] tx_cnt;

    // the start bit waits for a base tick, else it could be up to one base period short
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            tx_wait <= 1'b0;
        else if (accept)
            tx_wait <= 1'b1;
        else if (base_tick)
            tx_wait <= 1'b0;
    end

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            tx_state   <= TX_IDLE;
            tx_shift   <= 8'h00;
            tx_cnt     <= 3'h0;
            tx_ready_o <= 1'b0;
        end
        else
        begin
            tx_ready_o <= (tx_state == TX_IDLE) && !accept && !pend_valid;
            case (tx_state)
                TX_IDLE:
                    if (accept)
                    begin
                        tx_shift <= tx_data_i;
                        tx_state <= TX_START;
                    end
                TX_START:
                    if (tx_end)
                    begin
                        tx_cnt   <= 3'h0;
                        tx_state <= TX_DATA;
                    end
                TX_DATA:
                    if (tx_end)
                    begin
                        tx_shift <= tx_shift >> 1;
                        tx_cnt   <= tx_cnt + 3'h1;
                        if (tx_cnt == 3'(DATA_BITS - 1))
                            tx_state <= TX_STOP;
                    end
                TX_STOP:
                    if (tx_end)
                        tx_state <= TX_IDLE;
                default:
                    tx_state <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            txd_o <= 1'b1;
        else if ((tx_state == TX_START) && !tx_wait)
            txd_o <= 1'b0 ^ invert_i[LINE_TXD];
        else if (tx_state == TX_DATA)
            txd_o <= tx_shift[0] ^ invert_i[LINE_TXD];
        else
            txd_o <= 1'b1 ^ invert_i[LINE_TXD];
    end

    // ****************************************
    // pin synchronisers and handshake lines
    // ****************************************
    logic [4:0] pin_meta, pin_sync;

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            pin_meta <= 5'h1f;
            pin_sync <= 5'h1f;
        end
        else
        begin
            pin_meta <= {ring_indicate_n_i, carrier_detect_n_i, dsr_n_i, cts_n_i, rxd_i};
            pin_sync <= pin_meta;
        end
    end

    assign rx_line = pin_sync[0] ^ invert_i[LINE_RXD];

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cts_o <= 1'b0;
            dsr_o <= 1'b0;
            dcd_o <= 1'b0;
            ri_o  <= 1'b0;
        end
        else
        begin
            // a low pin means asserted unless its sense is inverted
            cts_o <= !(pin_sync[1] ^ invert_i[LINE_CTS]);
            dsr_o <= !(pin_sync[2] ^ invert_i[LINE_DSR]);
            dcd_o <= !(pin_sync[3] ^ invert_i[LINE_DCD]);
            ri_o  <= !(pin_sync[4] ^ invert_i[LINE_RI]);
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            rts_n_o <= 1'b1;
            dtr_n_o <= 1'b1;
        end
        else
        begin
            rts_n_o <= !rts_req_i ^ invert_i[LINE_RTS];
            dtr_n_o <= !dtr_req_i ^ invert_i[LINE_DTR];
        end
    end

    // ****************************************
    // power switch, bleed and identity
    // ****************************************
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            power_enable_n_o <= 1'b1;
            bleed_pulldown_o <= 1'b0;
            chip_id_o        <= CHIP_ID;
        end
        else
        begin
            power_enable_n_o <= power_off_i;
            bleed_pulldown_o <= bleed_enable_i && power_off_i;
        end
    end

    // ****************************************
    // receiver and flush timeout
    // ****************************************
    logic [7:0]  rx_shift;
    logic [2:0]  rx_cnt;
    logic        rx_pending;
    logic [17:0] ms_cnt;
    logic [7:0]  tmo_cnt;
    logic        ms_wrap;

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            rx_state         <= RX_IDLE;
            rx_shift         <= 8'h00;
            rx_cnt           <= 3'h0;
            rx_valid_o       <= 1'b0;
            rx_data_o        <= 8'h00;
            rx_frame_error_o <= 1'b0;
        end
        else
        begin
            rx_valid_o       <= 1'b0;
            rx_frame_error_o <= 1'b0;
            case (rx_state)
                RX_IDLE:
                    if (!rx_line)
                        rx_state <= RX_START;
                RX_START:
                    if (rx_mid)
                    begin
                        // a start bit gone high by mid-bit was a glitch
                        rx_state <= rx_line ? RX_IDLE : RX_DATA;
                        rx_cnt   <= 3'h0;
                    end
                RX_DATA:
                    if (rx_mid)
                    begin
                        rx_shift <= {rx_line, rx_shift[7:1]};
                        rx_cnt   <= rx_cnt + 3'h1;
                        if (rx_cnt == 3'(DATA_BITS - 1))
                            rx_state <= RX_STOP;
                    end
                RX_STOP:
                    if (rx_mid)
                    begin
                        rx_valid_o       <= rx_line;
                        rx_data_o        <= rx_shift;
                        rx_frame_error_o <= !rx_line;
                        rx_state         <= RX_IDLE;
                    end
                default:
                    rx_state <= RX_IDLE;
            endcase
        end
    end

    assign ms_wrap = (ms_cnt == 18'(MS_CYCLES - 1));

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            rx_pending <= 1'b0;
            ms_cnt     <= 18'h00000;
            tmo_cnt    <= 8'h00;
            rx_flush_o <= 1'b0;
        end
        else
        begin
            rx_flush_o <= 1'b0;
            if (rx_valid_o)
            begin
                // each byte with a good stop bit restarts the quiet time
                rx_pending <= 1'b1;
                ms_cnt     <= 18'h00000;
                tmo_cnt    <= 8'h00;
            end
            else if (rx_pending)
            begin
                ms_cnt <= ms_wrap ? 18'h00000 : ms_cnt + 18'h00001;
                if (ms_wrap && (tmo_cnt == act_timeout - 8'h01))
                begin
                    rx_flush_o <= 1'b1;
                    rx_pending <= 1'b0;
                end
                else if (ms_wrap)
                    tmo_cnt <= tmo_cnt + 8'h01;
            end
        end
    end

    // ****************************************
    // ring indicate wake
    // ****************************************
    logic [22:0] ri_cnt;
    logic        woken;

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            ri_cnt   <= 23'h000000;
            woken    <= 1'b0;
            resume_o <= 1'b0;
        end
        else
        begin
            resume_o <= 1'b0;
            if (pin_sync[4] ^ invert_i[LINE_RI])
            begin
                ri_cnt <= 23'h000000;
                woken  <= 1'b0;
            end
            else if (ri_cnt != 23'(WAKE_CYCLES))
                ri_cnt <= ri_cnt + 23'h000001;
            else if (!woken && remote_wake_enable_i && suspended_i)
            begin
                resume_o <= 1'b1;
                woken    <= 1'b1;
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    property p_bleed_only_power_off;
        @(posedge clock_i) disable iff (sys_rst_i) bleed_pulldown_o |-> power_enable_n_o;
    endproperty
    a_bleed_only_power_off: assert property (p_bleed_only_power_off) else $error("bleed while powered");

    property p_timeout_default;
        @(posedge clock_i) disable iff (sys_rst_i) !ever_applied |-> (act_timeout == TIMEOUT_RESET);
    endproperty
    a_timeout_default: assert property (p_timeout_default) else $error("timeout not default");

    property p_timeout_range;
        @(posedge clock_i) disable iff (sys_rst_i) act_timeout != 8'h00;
    endproperty
    a_timeout_range: assert property (p_timeout_range) else $error("timeout zero");

    property p_divisor_legal;
        @(posedge clock_i) disable iff (sys_rst_i) div_legal(act_int, act_frac);
    endproperty
    a_divisor_legal: assert property (p_divisor_legal) else $error("illegal divisor active");

    property p_change_at_boundary;
        @(posedge clock_i) disable iff (sys_rst_i)
            $changed(act_int) |-> ($past(tx_state) == TX_IDLE) && ($past(rx_state) == RX_IDLE);
    endproperty
    a_change_at_boundary: assert property (p_change_at_boundary) else $error("divisor changed mid frame");

    property p_flush_after_pending;
        @(posedge clock_i) disable iff (sys_rst_i) rx_flush_o |-> $past(rx_pending) ##1 !rx_flush_o;
    endproperty
    a_flush_after_pending: assert property (p_flush_after_pending) else $error("bad flush");

    property p_start_bit_low;
        @(posedge clock_i) disable iff (sys_rst_i)
            ((tx_state == TX_START) && !tx_wait) ##1 (tx_state == TX_START) |-> (txd_o == invert_i[LINE_TXD]);
    endproperty
    a_start_bit_low: assert property (p_start_bit_low) else $error("start bit not low");

    property p_rts_active_low;
        @(posedge clock_i) disable iff (sys_rst_i)
            ##1 1'b1 |-> (rts_n_o ^ $past(invert_i[LINE_RTS])) == !$past(rts_req_i);
    endproperty
    a_rts_active_low: assert property (p_rts_active_low) else $error("rts sense wrong");

    property p_resume_needs_wake;
        @(posedge clock_i) disable iff (sys_rst_i)
            resume_o |-> $past(remote_wake_enable_i) && (ri_cnt == 23'(WAKE_CYCLES)) ##1 !resume_o;
    endproperty
    a_resume_needs_wake: assert property (p_resume_needs_wake) else $error("resume without wake");

    c_tx_frame: cover property (@(posedge clock_i) disable iff (sys_rst_i) (tx_state == TX_STOP) && tx_end);
    c_rx_byte:  cover property (@(posedge clock_i) disable iff (sys_rst_i) rx_valid_o);
    c_flush:    cover property (@(posedge clock_i) disable iff (sys_rst_i) rx_flush_o);
    c_apply:    cover property (@(posedge clock_i) disable iff (sys_rst_i) apply);

endmodule : usb_uart_serial_port_core

// ===== uart_core_pkg.sv
// constants, types and helpers shared by the serial port core
package uart_core_pkg;

    // ****************************************
    // clocking and timing
    // ****************************************
    localparam int          CLK_HZ         = 250000000;
    localparam int          BASE_RATE      = 3000000;
    localparam logic [7:0]  BASE_STEP      = 8'(BASE_RATE / 1000000);
    localparam logic [7:0]  BASE_MOD       = 8'(CLK_HZ / 1000000);
    localparam int          TIMEOUT_STEP_MS = 1;
    localparam int          CYCLES_PER_MS  = CLK_HZ / 1000 * TIMEOUT_STEP_MS;
    localparam int          RI_WAKE_MS     = 20;
    localparam int          RI_WAKE_CYCLES = CLK_HZ / 1000 * RI_WAKE_MS;

    // ****************************************
    // divisor and timeout limits, reset values
    // ****************************************
    localparam int          DIV_INT_W      = 15;
    localparam int          DIV8_W         = 18;
    localparam logic [14:0] DIV_INT_MIN    = 15'h0002;
    localparam logic [14:0] DIV_INT_MAX    = 15'h4000;
    localparam logic [14:0] DIV_INT_RESET  = 15'h0138;
    localparam logic [2:0]  DIV_FRAC_RESET = 3'h4;
    localparam logic [7:0]  TIMEOUT_RESET  = 8'h10;
    localparam int          DATA_BITS      = 8;

    // ****************************************
    // line positions in the inversion mask
    // ****************************************
    localparam int LINE_TXD = 0;
    localparam int LINE_RXD = 1;
    localparam int LINE_RTS = 2;
    localparam int LINE_CTS = 3;
    localparam int LINE_DTR = 4;
    localparam int LINE_DSR = 5;
    localparam int LINE_DCD = 6;
    localparam int LINE_RI  = 7;

    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_type;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;

    function automatic logic div_legal(input logic [14:0] n, input logic [2:0] x);
        div_legal = ((n == 15'h0001) && (x == 3'h0)) ||
                    ((n >= DIV_INT_MIN) && (n <= DIV_INT_MAX));
    endfunction : div_legal

    // divisor in eighths of a base period
    function automatic logic [17:0] div_eighths(input logic [14:0] n, input logic [2:0] x);
        div_eighths = {n, x};
    endfunction : div_eighths

endpackage : uart_core_pkg

// ===== frac_baud_gen.sv
// fractional bit timer: mid-bit and end-of-bit pulses from the base tick
`timescale 1ns/100ps
module frac_baud_gen
    import uart_core_pkg::*;
(
    // clock and reset
    input  wire logic              clock_i,
    input  wire logic              sys_rst_i,
    // timing
    input  wire logic              base_tick_i,
    input  wire logic [DIV8_W-1:0] divisor8_i,
    input  wire logic              restart_i,
    output logic                   mid_o,
    output logic                   end_o
);
    import uart_core_pkg::*;

    logic [DIV8_W-1:0] acc;
    logic [DIV8_W-1:0] next_acc;
    logic [DIV8_W-1:0] half;

    // phase advances one eighth-unit step of 8 per base tick; carry is kept so the fraction averages out
    always_comb
    begin
        next_acc = acc + 18'h00008;
        half     = divisor8_i >> 1;
        mid_o    = base_tick_i && !restart_i && (acc < half) && (next_acc >= half);
        end_o    = base_tick_i && !restart_i && (next_acc >= divisor8_i);
    end

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            acc <= 18'h00000;
        else if (restart_i)
            acc <= 18'h00000;
        else if (end_o)
            acc <= next_acc - divisor8_i;
        else if (base_tick_i)
            acc <= next_acc;
    end

endmodule : frac_baud_gen

// ===== serial_partner.sv
// serial device model facing the core's transmit and receive pins
`timescale 1ns/100ps
module serial_partner #(parameter real BIT_NS = 666.667)(
    input  wire logic txd_i,
    output logic      rxd_o
);
    logic [7:0] got;
    logic       stop_bit;
    int         got_n = 0;
    initial rxd_o = 1'b1;
    // sample at mid-bit so divider rounding cannot move a sample across an edge
    always @(negedge txd_i)
    begin
        #(BIT_NS * 1.5);
        for (int i = 0; i < 8; i++)
        begin
            got[i] = txd_i;
            #(BIT_NS);
        end
        stop_bit = txd_i;
        got_n++;
    end
    task automatic send(input logic [7:0] b, input logic stop);
        rxd_o = 1'b0;
        #(BIT_NS);
        for (int i = 0; i < 8; i++)
        begin
            rxd_o = b[i];
            #(BIT_NS);
        end
        rxd_o = stop;
        #(BIT_NS);
        rxd_o = 1'b1;
        #(BIT_NS);
    endtask : send
endmodule : serial_partner

// ===== usb_uart_serial_port_core_tb.sv
// self-checking bench for the serial port core
`timescale 1ns/100ps
module usb_uart_serial_port_core_tb;
    import uart_core_pkg::*;
    localparam int          MS   = 50;
    localparam int          WAKE = 100;
    localparam logic [63:0] ID   = 64'h5a5a_0f0f_3c3c_9696; // arbitrary value
    logic clock_i = 0, sys_rst_i = 1, config_load_i = 0, bleed_enable_i = 0, power_off_i = 0;
    logic remote_wake_enable_i = 0, suspended_i = 0, tx_valid_i = 0, rts_req_i = 0, dtr_req_i = 0;
    logic cts_n_i = 1, dsr_n_i = 1, carrier_detect_n_i = 1, ring_indicate_n_i = 1, e;
    logic [14:0] divisor_int_i = 15'h0002;
    logic [2:0]  divisor_frac_i = 3'h0;
    logic [7:0]  timeout_ms_i = 8'h01, invert_i = 8'h00, tx_data_i = 8'h00, rx_data_o;
    logic [63:0] chip_id_o;
    logic config_error_o, resume_o, tx_ready_o, rx_valid_o, rx_frame_error_o, rx_flush_o, rxd_i;
    logic cts_o, dsr_o, dcd_o, ri_o, txd_o, rts_n_o, dtr_n_o, power_enable_n_o, bleed_pulldown_o;
    int   err_count = 0, check_count = 0, n;
    usb_uart_serial_port_core #(.MS_CYCLES(MS), .WAKE_CYCLES(WAKE), .CHIP_ID(ID)) uut (.*);
    serial_partner ext (.txd_i(txd_o), .rxd_o(rxd_i));
    always #2 clock_i = ~clock_i;
    task automatic tick();
        @(posedge clock_i);
        #1;
    endtask : tick
    task automatic chk(input string nm, input logic [63:0] x, input logic [63:0] g);
        check_count++;
        if (g !== x)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    task automatic load(input logic [14:0] ni, input logic [2:0] fr, output logic err);
        {divisor_int_i, divisor_frac_i} = {ni, fr};
        config_load_i = 1'b1;
        tick();
        config_load_i = 1'b0;
        err = config_error_o;
        repeat (3)
        begin
            tick();
            err |= config_error_o;
        end
    endtask : load
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done
    // the whole sequence needs about 5300 cycles
    initial
    begin
        repeat (60000) @(posedge clock_i);
        err_count++;
        test_done();
    end
    initial
    begin
        repeat (10) tick();
        sys_rst_i = 1'b0;
        repeat (3) tick();
        chk("idle", 4'hc, {txd_o, rts_n_o, power_enable_n_o, bleed_pulldown_o});
        load(15'h0001, 3'h1, e);
        chk("cfg_frac_on_one", 1'b1, e);
        load(15'h4001, 3'h0, e);
        chk("cfg_over_max", 1'b1, e);
        load(15'h4000, 3'h7, e);
        chk("cfg_max", 1'b0, e);
        for (int x = 0; x < 8; x++)
        begin
            load(15'h0002, 3'(x), e);
            chk("cfg_eighths", 1'b0, e);
        end
        load(15'h0002, 3'h0, e);
        for (int i = 0; i < 200 && tx_ready_o !== 1'b1; i++)
            tick();
        tx_data_i = 8'ha5;
        tx_valid_i = 1'b1;
        tick();
        tx_valid_i = 1'b0;
        for (int i = 0; i < 3000 && ext.got_n < 1; i++)
            tick();
        chk("tx_byte", 8'ha5, ext.got);
        chk("tx_stop", 1'b1, ext.stop_bit);
        fork
            ext.send(8'h3c, 1'b1);
        join_none
        for (int i = 0; i < 3000 && rx_valid_o !== 1'b1; i++)
            tick();
        chk("rx_byte", 8'h3c, rx_data_o);
        for (n = 0; n < 200 && rx_flush_o !== 1'b1; n++)
            tick();
        chk("flush_delay", 1'b1, n >= MS - 1 && n <= MS + 2);
        repeat (300) tick();
        fork
            ext.send(8'h81, 1'b0);
        join_none
        for (n = 0; n < 3000 && rx_frame_error_o !== 1'b1; n++)
            tick();
        chk("rx_frame_error", 1'b1, rx_frame_error_o);
        {rts_req_i, dtr_req_i, cts_n_i, dsr_n_i, carrier_detect_n_i} = 5'h1c;
        repeat (4) tick();
        chk("modem", 5'h03, {rts_n_o, dtr_n_o, cts_o, dsr_o, dcd_o});
        invert_i = 8'h0c;
        repeat (4) tick();
        chk("modem_inverted", 5'h17, {rts_n_o, dtr_n_o, cts_o, dsr_o, dcd_o});
        invert_i = 8'h00;
        {bleed_enable_i, power_off_i} = 2'h3;
        repeat (2) tick();
        chk("power_off", 2'h3, {power_enable_n_o, bleed_pulldown_o});
        power_off_i = 1'b0;
        repeat (2) tick();
        chk("power_on", 2'h0, {power_enable_n_o, bleed_pulldown_o});
        {remote_wake_enable_i, suspended_i, ring_indicate_n_i} = 3'h6;
        for (n = 0; n < 300 && resume_o !== 1'b1; n++)
            tick();
        chk("wake_delay", 1'b1, n >= WAKE && n <= WAKE + 8);
        chk("ri", 1'b1, ri_o);
        chk("chip_id", ID, chip_id_o);
        test_done();
    end
endmodule : usb_uart_serial_port_core_tb
